//--- hw/exec_core.sv
// Core datapath: program store, data memory, table reads, vectors.
`timescale 1ns/1ps
// What this block does
// [RL1] ALU result goes to the named register and status flags follow.
// [RL2] ALU offers add, subtract, carry forms, adjust, logic, rotate, inc, dec.
// [RL3] Program store is 4K words of 15 bits, fetched by the counter.
// [RL4] Any reset loads the counter with the reset vector.
// [RL5] Enabled external edge branches to its vector unless stack is full.
// [RL6] Enabled timer overflow branches to its own vector unless stack full.
// [RL7] Enabled time base overflow branches to its vector unless stack full.
// [RL8] Amplifiers and comparator share one vector, same enable and stack test.
// [RL9] Table pointer gives the low eight address bits of every table read.
// [RL10] Current-page read takes bits 11 to 8 from the program counter.
// [RL11] Last-page read forces address bits 11 to 8 to ones.
// [RL12] Low byte goes to the named data location, high part to high byte.
// [RL13] Unfilled high-byte bits read as zero.
// [RL14] Table high byte is read-only; only table reads change it.
// [RL15] Every table instruction takes two instruction cycles.
// [RL16] Software should mask interrupts around main-line table reads.
// [RL17] Data memory is bytes from zero: special area, then general area.
// [RL18] Every general purpose byte is readable and writable.
// [RL19] Protected special registers ignore program writes.
// [RL20] Bit set and clear change one bit, except dedicated bits.
// [RL21] Data memory is reachable through the memory pointers.
// [RL22] Indirect locations access the address held in their paired pointer.
// [RL23] Unused special locations read as zero.
// [RL24] Table reads leave the counter on its sequential course.
module exec_core
  import core_pkg::*;
#(
  parameter int PM_DEPTH = PM_WORDS
)
(
  input  wire logic                sys_clk_i,
  input  wire logic                arst_n_i,
  input  wire logic [6:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic [7:0]               rdata_o,
  input  wire logic                cmd_valid_i,
  input  wire cmd_t                cmd_i,
  input  wire logic                pgm_we_i,
  input  wire logic [PC_W-1:0]     pgm_addr_i,
  input  wire logic [PM_W-1:0]     pgm_data_i,
  input  wire logic                ext_pin_i,
  input  wire evt_t                evt_i,
  input  wire logic                stack_full_i,
  output logic [PC_W-1:0]          pc_o,
  output logic [PM_W-1:0]          instr_o,
  output logic                     busy_o,
  output logic                     int_ack_o
);
  typedef enum logic { S_IDLE, S_TBL } state_t;

  state_t          state_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc;
  logic [PC_W-1:0] tbl_addr_ff;
  logic [PM_W-1:0] tbl_word_ff;
  logic [PM_W-1:0] prog_ff [PM_DEPTH];
  logic [7:0]      gp_ff [GP_WORDS];
  logic [7:0]      acc_ff;
  logic [7:0]      mp0_ff;
  logic [7:0]      mp1_ff;
  logic [7:0]      tblp_ff;
  logic [7:0]      table_high_byte_ff;
  logic [3:0]      status_ff;
  logic [7:0]      intc0_ff;
  logic [7:0]      intc1_ff;
  logic [1:0]      edge_ff;
  logic            ext_prev_ff;
  logic [7:0]      tbl_dst_ff;
  logic [7:0]      rdata_ff;
  logic            ack_ff;
  logic [PC_W-1:0] instr_pc_ff;
  logic [PM_W-1:0] instr_ff;

  logic            cmd_go;
  logic            trd_go;
  logic [7:0]      cmd_ea;
  logic [7:0]      bus_ea;
  logic [7:0]      m_val;
  logic            wr_en;
  logic [6:0]      wr_a;
  logic [7:0]      wr_d;
  logic            ext_edge;
  logic [4:0]      pend;
  logic            int_take;
  logic [PC_W-1:0] vec_sel;
  logic [PC_W-1:0] tbl_addr;
  alu_out_t        alu_out;

  ////////////////////////////////////////////////////////////////////////////
  // Address resolution and read decode, shared by bus and commands.

  // Returns {invalid, address}; pointing an indirect slot at either indirect slot is void.
  function automatic logic [7:0] eff_addr(input logic [6:0] a);
    logic [6:0] t;
    t = a;
    if (a == A_INDIRECT_ACCESS_ZERO)
      t = mp0_ff[6:0];
    else if (a == A_INDIRECT_ACCESS_ONE)
      t = mp1_ff[6:0];
    return {((a == A_INDIRECT_ACCESS_ZERO) || (a == A_INDIRECT_ACCESS_ONE)) &&
            ((t == A_INDIRECT_ACCESS_ZERO) || (t == A_INDIRECT_ACCESS_ONE)), t};
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] ea);
    logic [7:0] v;
    v = RST_BYTE;
    if (!ea[7])
    begin
      case (ea[6:0])
        A_MP0:    v = mp0_ff;
        A_MP1:    v = mp1_ff;
        A_ACC:    v = acc_ff;
        A_PCL:    v = pc_ff[7:0];
        A_TBLP:   v = tblp_ff;
        A_TABLE_HIGH_BYTE:   v = table_high_byte_ff;
        A_STATUS: v = {4'h0, status_ff};
        A_INTC0:  v = intc0_ff;
        A_EDGE:   v = {6'h00, edge_ff};
        A_INTC1:  v = intc1_ff;
        default:
        begin
          if (ea[6:0] >= A_GP)                                  // RL17
            v = gp_ff[ea[5:0]];
          else
            v = RST_BYTE;                                       // RL23
        end
      endcase
    end
    return v;
  endfunction

  assign cmd_go   = cmd_valid_i && (state_ff == S_IDLE) && !wr_i && !rd_i;
  assign trd_go   = cmd_go && (cmd_i.kind == CMD_TRDC ||
                               cmd_i.kind == CMD_TRDL);
  // Kept in a process so that the register reads inside the functions
  // wake it; an assign would only follow the address arguments.
  always_comb
  begin
    cmd_ea = eff_addr(cmd_i.addr);                              // RL21
    bus_ea = eff_addr(addr_i);                                  // RL22
    m_val  = rd_byte(cmd_ea);
  end

  alu_unit u_alu (
    .op_i    (cmd_i.alu),
    .acc_i   (acc_ff),
    .mem_i   (m_val),
    .carry_i (status_ff[ST_C]),
    .half_i  (status_ff[ST_AC]),
    .out_o   (alu_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Single data memory write port. Table write-back outranks the bus.

  always_comb
  begin
    wr_en = 1'b0;
    wr_a  = cmd_ea[6:0];
    wr_d  = alu_out.res;
    if (state_ff == S_TBL)
    begin
      wr_en = !tbl_dst_ff[7];
      wr_a  = tbl_dst_ff[6:0];
      wr_d  = tbl_word_ff[7:0];                                 // RL12
    end
    else if (wr_i)
    begin
      wr_en = !bus_ea[7];
      wr_a  = bus_ea[6:0];
      wr_d  = wdata_i;
    end
    else if (cmd_go && !cmd_ea[7])
    begin
      case (cmd_i.kind)
        CMD_ALU:  wr_en = cmd_i.to_mem;                         // RL1
        CMD_BSET:
        begin
          wr_en = 1'b1;
          wr_d  = m_val | (8'h01 << cmd_i.bit_sel);             // RL20
        end
        CMD_BCLR:
        begin
          wr_en = 1'b1;
          wr_d  = m_val & ~(8'h01 << cmd_i.bit_sel);            // RL20
        end
        default:  wr_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en && wr_a >= A_GP)
      gp_ff[wr_a[5:0]] <= wr_d;                                 // RL18
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_ff  <= RST_BYTE;
      mp0_ff  <= RST_BYTE;
      mp1_ff  <= RST_BYTE;
      tblp_ff <= RST_BYTE;
      edge_ff <= 2'b00;
    end
    else
    begin
      if (cmd_go && cmd_i.kind == CMD_ALU && !cmd_i.to_mem)
        acc_ff <= alu_out.res;                                  // RL1
      else if (wr_en && wr_a == A_ACC)
        acc_ff <= wr_d;
      if (wr_en && wr_a == A_MP0)
        mp0_ff <= wr_d;
      if (wr_en && wr_a == A_MP1)
        mp1_ff <= wr_d;
      if (wr_en && wr_a == A_TBLP)
        tblp_ff <= wr_d;
      if (wr_en && wr_a == A_EDGE)
        edge_ff <= wr_d[1:0] & EDGE_WMSK[1:0];
    end
  end

  // Status flag bits; upper power flags are protected and read as zero.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      status_ff <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (cmd_go && cmd_i.kind == CMD_ALU && alu_out.upd[i])
          status_ff[i] <= alu_out.flags[i];                     // RL1
        else if (wr_en && wr_a == A_STATUS)
          status_ff[i] <= wr_d[i] & STATUS_WMSK[i];             // RL19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table read sequencing and program store.

  assign tbl_addr = (cmd_i.kind == CMD_TRDL) ?
                    {LAST_PAGE, tblp_ff} :                      // RL11
                    {pc_ff[11:8], tblp_ff};                     // RL10 RL9

  always_ff @(posedge sys_clk_i)
  begin
    if (pgm_we_i)
      prog_ff[pgm_addr_i] <= pgm_data_i;                        // RL3
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff    <= S_IDLE;
      tbl_addr_ff <= '0;
      tbl_word_ff <= '0;
      tbl_dst_ff  <= RST_BYTE;
      table_high_byte_ff     <= RST_BYTE;
    end
    else
    begin
      case (state_ff)
        S_IDLE:
        begin
          if (trd_go)
          begin
            state_ff    <= S_TBL;                               // RL15
            tbl_addr_ff <= tbl_addr;
            tbl_word_ff <= prog_ff[tbl_addr];
            tbl_dst_ff  <= cmd_ea;
          end
        end
        S_TBL:
        begin
          state_ff <= S_IDLE;
          // Only this path loads the high byte; bus writes never reach it.
          table_high_byte_ff  <= {1'b0, tbl_word_ff[14:8]};                // RL13 RL14
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags, edge detection and vector selection.

  always_comb
  begin
    case (edge_ff)
      2'b01:   ext_edge = ext_pin_i && !ext_prev_ff;
      2'b10:   ext_edge = !ext_pin_i && ext_prev_ff;
      2'b11:   ext_edge = ext_pin_i != ext_prev_ff;             // RL5
      default: ext_edge = 1'b0;
    endcase
  end

  assign pend = {intc1_ff[I1_MFF] & intc1_ff[I1_MFE],
                 intc1_ff[I1_TBF] & intc1_ff[I1_TBE],
                 intc0_ff[I0_T1F] & intc0_ff[I0_T1E],
                 intc0_ff[I0_T0F] & intc0_ff[I0_T0E],
                 intc0_ff[I0_EXTF] & intc0_ff[I0_EXTE]};

  // A full stack holds the flag but withholds the branch.
  assign int_take = (state_ff == S_IDLE) && !cmd_go && !wr_i &&
                    intc0_ff[I0_EMI] && !stack_full_i &&
                    (pend != 5'h00);                            // RL5

  always_comb
  begin
    if (pend[0])
      vec_sel = VEC_EXT;                                        // RL5
    else if (pend[1])
      vec_sel = VEC_TMR0;                                       // RL6
    else if (pend[2])
      vec_sel = VEC_TMR1;                                       // RL6
    else if (pend[3])
      vec_sel = VEC_TBASE;                                      // RL7
    else
      vec_sel = VEC_MULTI;                                      // RL8
  end

  // Hardware set wins over a software write or an acknowledge.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      intc0_ff    <= RST_BYTE;
      intc1_ff    <= RST_BYTE;
      ext_prev_ff <= 1'b0;
    end
    else
    begin
      logic [7:0] n0;
      logic [7:0] n1;
      n0 = intc0_ff;
      n1 = intc1_ff;
      if (wr_en && wr_a == A_INTC0)
        n0 = wr_d & INTC0_WMSK;
      if (wr_en && wr_a == A_INTC1)
        n1 = wr_d & INTC1_WMSK;
      if (int_take)
      begin
        n0[I0_EMI] = 1'b0;
        if (pend[0])
          n0[I0_EXTF] = 1'b0;
        else if (pend[1])
          n0[I0_T0F] = 1'b0;
        else if (pend[2])
          n0[I0_T1F] = 1'b0;
        else if (pend[3])
          n1[I1_TBF] = 1'b0;
        else
          n1[I1_MFF] = 1'b0;
      end
      n0[I0_EXTF] = n0[I0_EXTF] | ext_edge;
      n0[I0_T0F]  = n0[I0_T0F] | evt_i.t0;                      // RL6
      n0[I0_T1F]  = n0[I0_T1F] | evt_i.t1;
      n1[I1_TBF]  = n1[I1_TBF] | evt_i.tb;                      // RL7
      n1[I1_MFF]  = n1[I1_MFF] | evt_i.mf;                      // RL8
      intc0_ff    <= n0;
      intc1_ff    <= n1;
      ext_prev_ff <= ext_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter, fetch and bus read data.

  always_comb
  begin
    nxt_pc = pc_ff;
    if (cmd_go)
      nxt_pc = (cmd_i.kind == CMD_JMP) ? cmd_i.target :
               pc_ff + PC_STEP;                                 // RL24
    else if (int_take)
      nxt_pc = vec_sel;
    if (wr_en && wr_a == A_PCL)
      nxt_pc = {pc_ff[11:8], wr_d};
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_ff       <= VEC_RESET;                                 // RL4
      instr_pc_ff <= VEC_RESET;
      instr_ff    <= '0;
      ack_ff      <= 1'b0;
      rdata_ff    <= RST_BYTE;
    end
    else
    begin
      pc_ff       <= nxt_pc;
      instr_pc_ff <= nxt_pc;
      instr_ff    <= prog_ff[nxt_pc];                           // RL3
      ack_ff      <= int_take;
      rdata_ff    <= rd_i ? rd_byte(bus_ea) : RST_BYTE;         // RL22
    end
  end

  assign pc_o      = instr_pc_ff;
  assign instr_o   = instr_ff;
  assign busy_o    = (state_ff == S_TBL);
  assign int_ack_o = ack_ff;
  assign rdata_o   = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic started_ff;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      started_ff <= 1'b0;
    else
      started_ff <= 1'b1;
  end

  reset_vec_a: assert property (@(posedge sys_clk_i) // RL4
    !started_ff |-> pc_ff == VEC_RESET)
    else $error("counter not at reset vector");

  tbl_two_cycle_a: assert property (@(posedge sys_clk_i) // RL15
    disable iff (!arst_n_i)
    trd_go |=> busy_o ##1 !busy_o)
    else $error("table read not two cycles");

  tbl_last_page_a: assert property (@(posedge sys_clk_i) // RL11
    disable iff (!arst_n_i)
    trd_go && cmd_i.kind == CMD_TRDL |=>
      tbl_addr_ff == {LAST_PAGE, $past(tblp_ff)})
    else $error("last page address wrong");

  tbl_cur_page_a: assert property (@(posedge sys_clk_i) // RL10
    disable iff (!arst_n_i)
    trd_go && cmd_i.kind == CMD_TRDC |=>
      tbl_addr_ff == {$past(pc_ff[11:8]), $past(tblp_ff)})
    else $error("current page address wrong");

  tbl_high_a: assert property (@(posedge sys_clk_i) // RL12
    disable iff (!arst_n_i)
    trd_go |=> ##1 table_high_byte_ff == {1'b0, $past(prog_ff[tbl_addr][14:8], 2)} &&
      !table_high_byte_ff[7])
    else $error("high byte not loaded");

  table_high_byte_ro_a: assert property (@(posedge sys_clk_i) // RL14
    disable iff (!arst_n_i)
    state_ff == S_IDLE |=> $stable(table_high_byte_ff))
    else $error("high byte changed outside table read");

  tbl_pc_a: assert property (@(posedge sys_clk_i) // RL24
    disable iff (!arst_n_i)
    trd_go && !wr_en |=> pc_ff == $past(pc_ff) + PC_STEP ##1 $stable(pc_ff))
    else $error("table read moved the counter");

  int_vec_a: assert property (@(posedge sys_clk_i) // RL5
    disable iff (!arst_n_i)
    int_take |=> int_ack_o && pc_ff == $past(vec_sel) &&
      !intc0_ff[I0_EMI])
    else $error("interrupt branch wrong");

  int_stall_a: assert property (@(posedge sys_clk_i) // RL6
    disable iff (!arst_n_i)
    stack_full_i |=> !int_ack_o)
    else $error("branch taken with full stack");

  unused_zero_a: assert property (@(posedge sys_clk_i) // RL23
    disable iff (!arst_n_i)
    rd_i && addr_i == 7'h04 |=> rdata_o == 8'h00)
    else $error("unused location not zero");

  tbl_last_c: cover property (@(posedge sys_clk_i)
    disable iff (!arst_n_i) trd_go && cmd_i.kind == CMD_TRDL);
  int_take_c: cover property (@(posedge sys_clk_i)
    disable iff (!arst_n_i) int_take ##1 int_ack_o);
  indirect_c: cover property (@(posedge sys_clk_i)
    disable iff (!arst_n_i) cmd_go && cmd_i.addr == A_INDIRECT_ACCESS_ONE);
endmodule

//--- hw/core_pkg.sv
// Shared constants and types of the core datapath and table read unit.
package core_pkg;
  localparam int PC_W    = 12;
  localparam int PM_W    = 15;
  localparam int PM_WORDS = 4096;
  localparam int GP_WORDS = 64;

  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT   = 12'h004;
  localparam logic [11:0] VEC_TMR0  = 12'h008;
  localparam logic [11:0] VEC_TMR1  = 12'h00c;
  localparam logic [11:0] VEC_TBASE = 12'h010;
  localparam logic [11:0] VEC_MULTI = 12'h014;
  localparam logic [3:0]  LAST_PAGE = 4'hf;
  localparam logic [11:0] PC_STEP   = 12'h001;

  localparam logic [6:0] A_INDIRECT_ACCESS_ZERO   = 7'h00;
  localparam logic [6:0] A_MP0    = 7'h01;
  localparam logic [6:0] A_INDIRECT_ACCESS_ONE   = 7'h02;
  localparam logic [6:0] A_MP1    = 7'h03;
  localparam logic [6:0] A_ACC    = 7'h05;
  localparam logic [6:0] A_PCL    = 7'h06;
  localparam logic [6:0] A_TBLP   = 7'h07;
  localparam logic [6:0] A_TABLE_HIGH_BYTE   = 7'h08;
  localparam logic [6:0] A_STATUS = 7'h0a;
  localparam logic [6:0] A_INTC0  = 7'h0b;
  localparam logic [6:0] A_EDGE   = 7'h1b;
  localparam logic [6:0] A_INTC1  = 7'h1e;
  localparam logic [6:0] A_GP     = 7'h40;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] STATUS_WMSK = 8'h0f;
  localparam logic [7:0] INTC0_WMSK  = 8'h7f;
  localparam logic [7:0] INTC1_WMSK  = 8'h33;
  localparam logic [7:0] EDGE_WMSK   = 8'h03;

  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int I0_EMI = 0;
  localparam int I0_EXTE = 1;
  localparam int I0_T0E = 2;
  localparam int I0_T1E = 3;
  localparam int I0_EXTF = 4;
  localparam int I0_T0F = 5;
  localparam int I0_T1F = 6;
  localparam int I1_TBE = 0;
  localparam int I1_MFE = 1;
  localparam int I1_TBF = 4;
  localparam int I1_MFF = 5;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
    ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC,
    ALU_DEC, ALU_PASS
  } alu_op_t;

  typedef enum logic [2:0] {
    CMD_ALU, CMD_BSET, CMD_BCLR, CMD_TRDC, CMD_TRDL, CMD_JMP
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    alu_op_t     alu;
    logic        to_mem;
    logic [6:0]  addr;
    logic [2:0]  bit_sel;
    logic [11:0] target;
  } cmd_t;

  typedef struct packed {
    logic       mf;
    logic       tb;
    logic       t1;
    logic       t0;
  } evt_t;

  typedef struct packed {
    logic [7:0] res;
    logic [3:0] flags;
    logic [3:0] upd;
  } alu_out_t;
endpackage

//--- hw/alu_unit.sv
// Eight-bit arithmetic and logic unit with status flag results.
`timescale 1ns/1ps
module alu_unit
  import core_pkg::*;
(
  input  wire alu_op_t  op_i,
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] mem_i,
  input  wire logic       carry_i,
  input  wire logic       half_i,
  output alu_out_t        out_o
);
  always_comb
  begin
    logic [7:0] b;
    logic       ci;
    logic [8:0] s;
    logic [4:0] h;
    b = mem_i;
    ci = 1'b0;
    s = '0;
    h = '0;
    out_o = '0;
    case (op_i)                                                 // RL2
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
      begin
        // Subtract adds the inverse; carry set means no borrow.
        if (op_i == ALU_SUB || op_i == ALU_SBC)
          b = ~mem_i;
        if (op_i == ALU_SUB)
          ci = 1'b1;
        else if (op_i != ALU_ADD)
          ci = carry_i;
        s = {1'b0, acc_i} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, acc_i[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        out_o.res = s[7:0];
        out_o.flags[ST_C] = s[8];
        out_o.flags[ST_AC] = h[4];
        out_o.flags[ST_OV] = (acc_i[7] == b[7]) && (s[7] != acc_i[7]);
        out_o.upd = 4'hf;
      end
      ALU_DAA:
      begin
        s = {1'b0, acc_i};
        if (acc_i[3:0] > 4'h9 || half_i)
          s = s + 9'h006;
        if (s[8:4] > 5'h09 || carry_i)
          s = s + 9'h060;
        out_o.res = s[7:0];
        out_o.flags[ST_C] = s[8] | carry_i;
        out_o.upd[ST_C] = 1'b1;
      end
      ALU_AND, ALU_OR, ALU_XOR, ALU_CPL, ALU_INC, ALU_DEC:
      begin
        case (op_i)
          ALU_AND: out_o.res = acc_i & mem_i;
          ALU_OR:  out_o.res = acc_i | mem_i;
          ALU_XOR: out_o.res = acc_i ^ mem_i;
          ALU_CPL: out_o.res = ~mem_i;
          ALU_INC: out_o.res = mem_i + 8'h01;
          default: out_o.res = mem_i - 8'h01;
        endcase
        out_o.upd[ST_Z] = 1'b1;
      end
      ALU_RR:  out_o.res = {mem_i[0], mem_i[7:1]};
      ALU_RL:  out_o.res = {mem_i[6:0], mem_i[7]};
      ALU_RRC:
      begin
        out_o.res = {carry_i, mem_i[7:1]};
        out_o.flags[ST_C] = mem_i[0];
        out_o.upd[ST_C] = 1'b1;
      end
      ALU_RLC:
      begin
        out_o.res = {mem_i[6:0], carry_i};
        out_o.flags[ST_C] = mem_i[7];
        out_o.upd[ST_C] = 1'b1;
      end
      default: out_o.res = mem_i;
    endcase
    out_o.flags[ST_Z] = (out_o.res == 8'h00);
  end
endmodule

//--- testbench/seq_model.sv
// Behavioural instruction sequencer that issues one command per request.
`timescale 1ns/1ps
module seq_model
  import core_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic go_i,
  input  wire cmd_t c_i,
  input  wire logic busy_i,
  output logic      cmd_valid_o,
  output cmd_t      cmd_o,
  output logic      done_o
);
  logic wait_ff;

  // The strobe lasts one cycle; done then waits for busy to drop.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
      wait_ff     <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= go_i;
      if (go_i)
        cmd_o <= c_i;
      wait_ff <= cmd_valid_o | (wait_ff & busy_i);
    end
  end

  assign done_o = wait_ff & ~busy_i;
endmodule

//--- testbench/exec_core_test.sv
// Self-checking testbench of the core datapath and table read unit.
`timescale 1ns/1ps
module exec_core_test import core_pkg::*;;
  logic             sys_clk_i = 1'b0;
  logic             arst_n_i, wr_i, rd_i, cmd_valid_i, pgm_we_i;
  logic             ext_pin_i, stack_full_i, busy_o, int_ack_o, go, done;
  logic [6:0]       addr_i;
  logic [7:0]       wdata_i, rdata_o;
  cmd_t             cmd_i, cmd_r;
  logic [PC_W-1:0]  pgm_addr_i, pc_o, pc0;
  logic [PM_W-1:0]  pgm_data_i, instr_o;
  evt_t             evt_i;
  int               errors = 0;
  int               compares = 0;
  int               nb;
  logic [7:0]       v0 [4] = '{8'h03, 8'h09, 8'h01, 8'h01};
  logic [7:0]       v1 [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
  int               sr [4] = '{4, 1, 2, 3};
  logic [11:0]      vc [4] = '{VEC_EXT, VEC_TMR1, VEC_TBASE, VEC_MULTI};

  always #5 sys_clk_i = ~sys_clk_i;

  exec_core i_dut (.sys_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .cmd_valid_i, .cmd_i, .pgm_we_i, .pgm_addr_i, .pgm_data_i,
    .ext_pin_i, .evt_i, .stack_full_i, .pc_o, .instr_o, .busy_o, .int_ack_o);

  seq_model i_seq (.sys_clk_i, .arst_n_i, .go_i(go), .c_i(cmd_r),
    .busy_i(busy_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .done_o(done));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask

  task automatic pw(input logic [11:0] a, input logic [14:0] d);
    @(posedge sys_clk_i);
    pgm_we_i <= 1'b1;
    pgm_addr_i <= a;
    pgm_data_i <= d;
    @(posedge sys_clk_i);
    pgm_we_i <= 1'b0;
  endtask

  // Counts busy cycles so that the two-cycle table timing is visible.
  task automatic exec(input cmd_t c, output int busy_n);
    int n;
    busy_n = 0;
    @(posedge sys_clk_i);
    go <= 1'b1;
    cmd_r <= c;
    @(posedge sys_clk_i);
    go <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge sys_clk_i);
      #1;
      busy_n += (busy_o === 1'b1);
      if (done === 1'b1)
        break;
    end
  endtask

  task automatic fire(input int src);
    @(posedge sys_clk_i);
    ext_pin_i <= (src == 4);
    evt_i <= evt_t'(4'h1 << src);
    @(posedge sys_clk_i);
    evt_i <= '0;
  endtask

  task automatic wait_ack(input logic exp, input logic [11:0] vec);
    int n;
    for (n = 0; n < 8; n++)
    begin
      @(posedge sys_clk_i);
      #1;
      if (int_ack_o === 1'b1)
        break;
    end
    chk({15'h0, n < 8}, {15'h0, exp});
    if (exp)
      chk({4'h0, pc_o}, {4'h0, vec});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    errors++;
    wrap_up();
  end

  initial
  begin
    {arst_n_i, wr_i, rd_i, pgm_we_i, ext_pin_i, stack_full_i, go} = '0;
    {addr_i, wdata_i, pgm_addr_i, pgm_data_i, evt_i, cmd_r} = '0;
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk({4'h0, pc_o}, {4'h0, VEC_RESET});
    wr(A_GP, 8'h5a);
    rd(A_GP, 8'h5a);
    wr(7'h7f, 8'ha5);
    rd(7'h7f, 8'ha5);
    wr(7'h04, 8'h77);
    rd(7'h04, 8'h00);
    wr(A_STATUS, 8'hff);
    rd(A_STATUS, 8'h0f);
    wr(A_MP0, 8'h41);
    wr(A_INDIRECT_ACCESS_ZERO, 8'h3c);
    rd(7'h41, 8'h3c);
    wr(A_MP1, 8'h02);
    rd(A_INDIRECT_ACCESS_ONE, 8'h00);
    wr(A_ACC, 8'hff);
    wr(A_GP, 8'h01);
    exec(cmd_t'{CMD_ALU, ALU_ADD, 1'b0, A_GP, 3'h0, 12'h000}, nb);
    rd(A_ACC, 8'h00);
    rd(A_STATUS, 8'h07);
    exec(cmd_t'{CMD_ALU, ALU_INC, 1'b1, A_GP, 3'h0, 12'h000}, nb);
    rd(A_GP, 8'h02);
    exec(cmd_t'{CMD_ALU, ALU_SUB, 1'b0, A_GP, 3'h0, 12'h000}, nb);
    rd(A_ACC, 8'hfe);
    rd(A_STATUS, 8'h00);
    wr(7'h44, 8'ha5);
    exec(cmd_t'{CMD_BSET, ALU_PASS, 1'b0, 7'h44, 3'h1, 12'h000}, nb);
    exec(cmd_t'{CMD_BCLR, ALU_PASS, 1'b0, 7'h44, 3'h7, 12'h000}, nb);
    rd(7'h44, 8'h27);
    // Interrupts stay off around main-line table reads.
    wr(A_INTC0, 8'h00);
    pw(12'hf06, 15'h7f1b);
    wr(A_TBLP, 8'h06);
    pc0 = pc_o;
    exec(cmd_t'{CMD_TRDL, ALU_PASS, 1'b0, 7'h42, 3'h0, 12'h000}, nb);
    chk(16'(nb), 16'h0001);
    chk({4'h0, pc_o}, {4'h0, pc0 + PC_STEP});
    rd(7'h42, 8'h1b);
    rd(A_TABLE_HIGH_BYTE, 8'h7f);
    wr(A_TABLE_HIGH_BYTE, 8'h55);
    rd(A_TABLE_HIGH_BYTE, 8'h7f);
    pw(12'h312, 15'h2a6c);
    exec(cmd_t'{CMD_JMP, ALU_PASS, 1'b0, 7'h00, 3'h0, 12'h312}, nb);
    chk({4'h0, pc_o}, 16'h0312);
    chk({1'b0, instr_o}, 16'h2a6c);
    pw(12'h306, 15'h0155);
    exec(cmd_t'{CMD_TRDC, ALU_PASS, 1'b0, 7'h43, 3'h0, 12'h000}, nb);
    rd(7'h43, 8'h55);
    rd(A_TABLE_HIGH_BYTE, 8'h01);
    wr(A_INTC0, 8'h05);
    stack_full_i <= 1'b1;
    fire(0);
    wait_ack(1'b0, VEC_TMR0);
    rd(A_INTC0, 8'h25);
    @(posedge sys_clk_i);
    stack_full_i <= 1'b0;
    wait_ack(1'b1, VEC_TMR0);
    rd(A_INTC0, 8'h04);
    wr(A_EDGE, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_INTC1, v1[i]);
      wr(A_INTC0, v0[i]);
      fire(sr[i]);
      wait_ack(1'b1, vc[i]);
    end
    // Both-edge mode on a rise, then falling-edge mode on a fall.
    wr(A_EDGE, 8'h03);
    wr(A_INTC0, 8'h03);
    fire(4);
    wait_ack(1'b1, VEC_EXT);
    wr(A_EDGE, 8'h02);
    wr(A_INTC0, 8'h03);
    fire(1);
    wait_ack(1'b1, VEC_EXT);
    wrap_up();
  end
endmodule
